// File: intc_params.svh
// Purpose: constants of the interrupt readback, poll and cascade block
// Assumes: included by the package file; the design modules use its macros
// Notes:   offsets are indexes inside the board's block of four ports
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

`define PORT_EVEN        1'h0
`define PORT_ODD         1'h1
`define OFS_MASTER_EVEN  2'h0
`define OFS_MASTER_ODD   2'h1
`define OFS_SLAVE_EVEN   2'h2
`define OFS_SLAVE_ODD    2'h3
`define ONBOARD_SLAVE_IN 3'h1
`define SLAVE_VI_INPUT   3'h3

`define CMD_INIT_BIT     4
`define CMD_OP_BIT       3
`define CMD_POLL_BIT     2
`define CMD_RDVALID_BIT  1
`define CMD_RDISR_BIT    0
`define CMD_EOI_NS_BIT   5
`define CMD_EOI_SP_BIT   6
`define MODE_AEOI_BIT    0
`define MODE_CALL_BIT    1
`define MODE_MASTER_BIT  2

`define CALL_OPCODE      8'hCD
`define POLL_NONE_WORD   8'h07
`define DEFAULT_LEVEL    3'h7
`define RST_REG8         8'h00
`define RST_CAS          3'h0
`define RST_CASC_MASTER  8'h02
`define RST_CASC_SLAVE   8'h01
`define RST_VI_N         8'hFF

`endif

// File: intc_pkg.sv
// Purpose: types and shared helpers of the interrupt block
// Assumes: intc_params.svh holds the named constants; pick and chip_int use plain literals
// Notes:   level 0 ranks highest
`include "intc_params.svh"

package intc_pkg;

    typedef enum logic [1:0] {ACK_IDLE, ACK_BYTE1, ACK_BYTE2} ack_st_t;
    typedef enum logic [1:0] {INIT_NONE, INIT_VEC, INIT_CASC, INIT_MODE} init_st_t;

    typedef struct packed {
        logic       found;
        logic [2:0] lvl;
    } pick_t;

    typedef struct packed {
        logic [7:0] pend;
        logic [7:0] in_service_levels;
        logic [7:0] level_mask;
        logic       sel_isr;
        logic       poll_armed;
        init_st_t   init_st;
        logic [7:0] vector;
        logic [7:0] casc;
        logic       aeoi;
        logic       byte_call;
        logic       is_master;
        ack_st_t    ack_st;
        logic [2:0] ack_lvl;
        logic [2:0] cas;
    } ctl_t;

    function automatic pick_t pick(input logic [7:0] bits);
        pick_t r;
        r = '{found: 1'b0, lvl: 3'h0};
        for (int k = 7; k >= 0; k--) begin
            if (bits[k]) begin
                r = '{found: 1'b1, lvl: 3'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic chip_int(input ctl_t c);
        pick_t hp;
        pick_t hs;
        hp = pick(c.pend & ~c.level_mask);
        hs = pick(c.in_service_levels);
        return hp.found && (!hs.found || hp.lvl < hs.lvl);
    endfunction

endpackage

// File: vi_sync.sv
// Purpose: three-stage synchroniser for the bus request lines
// Assumes: inputs are asynchronous to i_clk_sys
// Notes:   a bit changes only once stages two and three agree
`timescale 1ns/1ps

module vi_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_stable
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
    } sync_t;

    sync_t st_ff;
    sync_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int k = 0; k < WIDTH; k++) begin
            if (st_ff.s2[k] == st_ff.s3[k]) begin
                nxt_st.stable[k] = st_ff.s3[k];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_ff <= {4{WIDTH'(`RST_VI_N)}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_stable = st_ff.stable;
endmodule // vi_sync

// File: interrupt_readback_poll_cascade.sv
// Purpose: board interrupt block, master and on-board slave with readback, poll, cascade
// Assumes: host strobes and acknowledge pulses are one-cycle pulses on i_clk_sys
// Notes:   read and vector data appear one edge after the strobe
//
// How it works
// [R1] after a read-register command even reads return pending or in-service
// [R2] register selection is kept across reads; poll takes over only one read
// [R3] initialization selects the pending register for even reads
// [R4] odd reads return the mask directly
// [R5] odd writes load the mask directly, no selection step
// [R6] each controller holds pending, in-service and mask, one bit per level
// [R7] after poll the next even read acknowledges, sets in-service, returns poll word
// [R8] poll word top bit flags a request, low three bits its level
// [R9] poll with no request returns top bit zero, low bits ones
// [R10] host writes a poll command before every poll read
// [R11] host fully initializes each controller, even when only polling
// [R12] master plus slaves give up to sixty-four levels
// [R13] master learns slave inputs, slaves learn their identifier at init
// [R14] interrupt raised only when the highest unmasked request outranks every in-service level
// [R15] first acknowledge: master drives slave id on cascade lines, call opcode
// [R16] addressed slave drives its vector for the rest of the acknowledge
// [R17] cascaded acknowledge sets in-service in master and slave
// [R18] non-slave input acknowledged leaves cascade lines at zero
// [R19] slave output drives master input one; bus line one feeds slave input three
// [R20] cascade lines go onto the low address lines during acknowledge
// [R21] buffer enable drives vector data onto the data-in bus
// [R22] master at ports zero and one, slave at two and three
// [R23] even address maps to first and third port, odd to second and fourth
`timescale 1ns/1ps

module interrupt_readback_poll_cascade
    import intc_pkg::*;
#(
    parameter logic [7:0] VEC_PAGE = 8'h00
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_io_rd,
    input  wire logic       i_io_wr,
    input  wire logic [1:0] i_port_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_ack,
    input  wire logic [7:0] i_vi_n,
    input  wire logic [7:0] i_local_req,
    output logic            o_int,
    output logic [7:0]      o_rdata,
    output logic            o_rd_valid,
    output logic            o_buf_en,
    output logic            o_addr_drive,
    output logic [2:0]      o_addr_low
);
    typedef struct packed {
        ctl_t [1:0] ctl;
        logic       int_q;
        logic [7:0] dout;
        logic       dvalid;
        logic       buf_en;
        logic       addr_drive;
        logic [2:0] addr_low;
    } top_t;

    localparam ctl_t CTL_RST_M = '{pend: `RST_REG8, in_service_levels: `RST_REG8, level_mask: `RST_REG8,
        sel_isr: 1'b0, poll_armed: 1'b0, init_st: INIT_NONE, vector: `RST_REG8,
        casc: `RST_CASC_MASTER, aeoi: 1'b0, byte_call: 1'b0, is_master: 1'b1,
        ack_st: ACK_IDLE, ack_lvl: `RST_CAS, cas: `RST_CAS};
    localparam ctl_t CTL_RST_S = '{pend: `RST_REG8, in_service_levels: `RST_REG8, level_mask: `RST_REG8,
        sel_isr: 1'b0, poll_armed: 1'b0, init_st: INIT_NONE, vector: `RST_REG8,
        casc: `RST_CASC_SLAVE, aeoi: 1'b0, byte_call: 1'b0, is_master: 1'b0,
        ack_st: ACK_IDLE, ack_lvl: `RST_CAS, cas: `RST_CAS};
    localparam top_t ST_RST = '{ctl: {CTL_RST_S, CTL_RST_M}, int_q: 1'b0,
        dout: `RST_REG8, dvalid: 1'b0, buf_en: 1'b0, addr_drive: 1'b0,
        addr_low: `RST_CAS};

    top_t       st_ff;
    top_t       nxt_st;
    logic [7:0] vi_n_stable;
    logic [7:0] m_req;
    logic [7:0] s_req;

    vi_sync #(
        .WIDTH (8)
    ) u_vi_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_async   (i_vi_n),
        .o_stable  (vi_n_stable)
    );

    // bus lines are active low; on-board slave sits on master input one
    always_comb begin
        m_req                    = ~vi_n_stable;                         // [R19]
        m_req[`ONBOARD_SLAVE_IN] = chip_int(st_ff.ctl[1]);               // [R19]
        s_req                    = i_local_req;
        s_req[`SLAVE_VI_INPUT]   = ~vi_n_stable[`ONBOARD_SLAVE_IN];      // [R19]
    end

    always_comb begin
        ctl_t       c;
        pick_t      hp;
        pick_t      hs;
        logic       wr_i;
        logic       rd_i;
        logic       sel;
        logic [2:0] cas_in;
        logic       poll_wr;
        c      = st_ff.ctl[0];
        hp     = '{found: 1'b0, lvl: 3'h0};
        hs     = '{found: 1'b0, lvl: 3'h0};
        wr_i   = 1'b0;
        rd_i   = 1'b0;
        sel    = 1'b0;
        cas_in = st_ff.ctl[0].cas;
        poll_wr = 1'b0;
        nxt_st        = st_ff;
        nxt_st.dvalid = 1'b0;
        nxt_st.buf_en = 1'b0;
        for (int i = 0; i < 2; i++) begin
            c      = st_ff.ctl[i];
            poll_wr = 1'b0;
            c.pend = (i == 0) ? m_req : s_req;                           // [R6]
            hp     = pick(st_ff.ctl[i].pend & ~st_ff.ctl[i].level_mask);
            hs     = pick(st_ff.ctl[i].in_service_levels);
            wr_i   = i_io_wr && (i_port_addr[1] == 1'(i));               // [R22]
            rd_i   = i_io_rd && (i_port_addr[1] == 1'(i));               // [R22]
            // writes: even port takes commands, odd port the init words or mask
            if (wr_i && i_port_addr[0] == `PORT_EVEN) begin              // [R23]
                if (i_wdata[`CMD_INIT_BIT]) begin
                    c.in_service_levels        = `RST_REG8;
                    c.level_mask        = `RST_REG8;
                    c.sel_isr    = 1'b0;                                 // [R3]
                    c.poll_armed = 1'b0;
                    c.init_st    = INIT_VEC;
                end else if (i_wdata[`CMD_OP_BIT]) begin
                    if (i_wdata[`CMD_POLL_BIT]) begin
                        c.poll_armed = 1'b1;                             // [R7]
                        poll_wr      = 1'b1;
                    end else if (i_wdata[`CMD_RDVALID_BIT]) begin
                        c.sel_isr = i_wdata[`CMD_RDISR_BIT];             // [R1] [R2]
                    end
                end else if (i_wdata[`CMD_EOI_SP_BIT]) begin
                    c.in_service_levels[i_wdata[2:0]] = 1'b0;                          // [R17]
                end else if (i_wdata[`CMD_EOI_NS_BIT] && hs.found) begin
                    c.in_service_levels[hs.lvl] = 1'b0;                                // [R17]
                end
            end else if (wr_i) begin
                unique case (c.init_st)
                    INIT_VEC: begin
                        c.vector  = i_wdata;
                        c.init_st = INIT_CASC;
                    end
                    INIT_CASC: begin
                        c.casc    = i_wdata;                             // [R13] [R12]
                        c.init_st = INIT_MODE;
                    end
                    INIT_MODE: begin
                        c.aeoi      = i_wdata[`MODE_AEOI_BIT];
                        c.byte_call = i_wdata[`MODE_CALL_BIT];
                        c.is_master = i_wdata[`MODE_MASTER_BIT];
                        c.init_st   = INIT_NONE;
                    end
                    INIT_NONE: begin
                        c.level_mask = i_wdata;                                 // [R5]
                    end
                endcase
            end
            // reads: poll consumes one read, selection itself stays untouched
            if (rd_i) begin
                nxt_st.dvalid = 1'b1;
                if (i_port_addr[0] == `PORT_ODD) begin                   // [R23]
                    nxt_st.dout = st_ff.ctl[i].level_mask;                      // [R4] [R5]
                end else if (st_ff.ctl[i].poll_armed) begin
                    // set wins: a poll written along with the read stays armed
                    c.poll_armed = poll_wr;                              // [R7]
                    if (hp.found) begin
                        nxt_st.dout   = {1'b1, 4'h0, hp.lvl};            // [R8]
                        c.in_service_levels[hp.lvl] = 1'b1;                            // [R7]
                    end else begin
                        nxt_st.dout = `POLL_NONE_WORD;                   // [R9]
                    end
                end else begin
                    nxt_st.dout = st_ff.ctl[i].sel_isr ? st_ff.ctl[i].in_service_levels
                                                       : st_ff.ctl[i].pend; // [R1] [R2]
                end
            end
            // acknowledge sequence; a request gone before the first pulse reads as 7
            cas_in = st_ff.ctl[0].cas;
            sel    = c.is_master ? !c.casc[c.ack_lvl]
                                 : (cas_in == c.casc[2:0]);              // [R16]
            if (i_ack) begin
                unique case (c.ack_st)
                    ACK_IDLE: begin
                        c.ack_lvl = hp.found ? hp.lvl : `DEFAULT_LEVEL;
                        c.ack_st  = ACK_BYTE1;
                        if (c.is_master) begin
                            c.in_service_levels[c.ack_lvl] = 1'b1;                     // [R17]
                            c.cas = c.casc[c.ack_lvl] ? c.ack_lvl : `RST_CAS; // [R15] [R18]
                            if (c.byte_call) begin
                                nxt_st.dout   = `CALL_OPCODE;            // [R15]
                                nxt_st.dvalid = 1'b1;
                                nxt_st.buf_en = 1'b1;                    // [R21]
                            end
                        end
                    end
                    ACK_BYTE1: begin
                        if (sel) begin
                            nxt_st.dout   = c.byte_call ? {c.vector[7:5], c.ack_lvl, 2'h0}
                                                        : {c.vector[7:3], c.ack_lvl}; // [R16]
                            nxt_st.dvalid = 1'b1;
                            nxt_st.buf_en = 1'b1;                        // [R21]
                            if (!c.is_master) begin
                                c.in_service_levels[c.ack_lvl] = 1'b1;                 // [R17]
                            end
                        end
                        c.ack_st = c.byte_call ? ACK_BYTE2 : ACK_IDLE;
                    end
                    ACK_BYTE2: begin
                        if (sel) begin
                            nxt_st.dout   = VEC_PAGE;                    // [R16]
                            nxt_st.dvalid = 1'b1;
                            nxt_st.buf_en = 1'b1;                        // [R21]
                        end
                        c.ack_st = ACK_IDLE;
                    end
                    default: begin
                        c.ack_st = ACK_IDLE;
                    end
                endcase
                if (c.ack_st == ACK_IDLE) begin
                    c.cas = `RST_CAS;
                    if (c.aeoi && (c.is_master || sel)) begin
                        c.in_service_levels[c.ack_lvl] = 1'b0;
                    end
                end
            end
            nxt_st.ctl[i] = c;
        end
        nxt_st.int_q      = chip_int(st_ff.ctl[0]);                      // [R14]
        nxt_st.addr_drive = nxt_st.ctl[0].ack_st != ACK_IDLE;            // [R20]
        nxt_st.addr_low   = nxt_st.ctl[0].cas;                           // [R20]
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_int        = st_ff.int_q;
    assign o_rdata      = st_ff.dout;
    assign o_rd_valid   = st_ff.dvalid;
    assign o_buf_en     = st_ff.buf_en;
    assign o_addr_drive = st_ff.addr_drive;
    assign o_addr_low   = st_ff.addr_low;

    // checks on the master, which carries the cascade logic, plus the slave odd-port mask readback
    pick_t m_hp;
    assign m_hp = pick(st_ff.ctl[0].pend & ~st_ff.ctl[0].level_mask);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    a_mask_read: assert property (i_io_rd && i_port_addr == `OFS_MASTER_ODD && !i_ack // [R4]
        |=> o_rd_valid && o_rdata == $past(st_ff.ctl[0].level_mask))
        else $error("mask readback wrong");
    a_slave_port_map: assert property (i_io_rd && i_port_addr == `OFS_SLAVE_ODD && !i_ack // [R23]
        |=> o_rdata == $past(st_ff.ctl[1].level_mask))
        else $error("slave odd port does not return slave mask");
    a_sel_reg_read: assert property (i_io_rd && i_port_addr == `OFS_MASTER_EVEN // [R1]
        && !i_ack && !st_ff.ctl[0].poll_armed
        |=> o_rdata == ($past(st_ff.ctl[0].sel_isr) ? $past(st_ff.ctl[0].in_service_levels)
                                                   : $past(st_ff.ctl[0].pend)))
        else $error("selected register not returned");
    a_init_default: assert property (i_io_wr && i_port_addr == `OFS_MASTER_EVEN // [R3]
        && i_wdata[`CMD_INIT_BIT] && !i_ack
        |=> !st_ff.ctl[0].sel_isr && st_ff.ctl[0].level_mask == `RST_REG8
            && st_ff.ctl[0].init_st == INIT_VEC)
        else $error("init did not select pending register");
    a_mask_write: assert property (i_io_wr && i_port_addr == `OFS_MASTER_ODD // [R5]
        && st_ff.ctl[0].init_st == INIT_NONE |=> st_ff.ctl[0].level_mask == $past(i_wdata))
        else $error("mask write lost");
    a_poll_word: assert property (i_io_rd && i_port_addr == `OFS_MASTER_EVEN && !i_ack // [R8]
        && st_ff.ctl[0].poll_armed && m_hp.found
        |=> o_rdata[7] && o_rdata[2:0] == $past(m_hp.lvl) && st_ff.ctl[0].in_service_levels[o_rdata[2:0]])
        else $error("poll word or in-service wrong");
    a_poll_none: assert property (i_io_rd && i_port_addr == `OFS_MASTER_EVEN && !i_ack // [R9]
        && st_ff.ctl[0].poll_armed && !m_hp.found |=> o_rdata == `POLL_NONE_WORD)
        else $error("empty poll word wrong");
    a_poll_once: assert property (i_io_rd && i_port_addr == `OFS_MASTER_EVEN // [R7]
        && st_ff.ctl[0].poll_armed && !(i_io_wr) |=> !st_ff.ctl[0].poll_armed)
        else $error("poll covers more than one read");
    a_cas_slave: assert property (i_ack && st_ff.ctl[0].ack_st == ACK_IDLE // [R15]
        && st_ff.ctl[0].is_master && m_hp.found && st_ff.ctl[0].casc[m_hp.lvl]
        |=> o_addr_drive && o_addr_low == $past(m_hp.lvl))
        else $error("cascade lines not driven with slave id");
    a_cas_default: assert property (i_ack && st_ff.ctl[0].ack_st == ACK_IDLE // [R18]
        && st_ff.ctl[0].is_master && m_hp.found && !st_ff.ctl[0].casc[m_hp.lvl]
        |=> o_addr_low == `RST_CAS)
        else $error("cascade lines left non-zero");
    a_call_byte: assert property (i_ack && st_ff.ctl[0].ack_st == ACK_IDLE // [R15]
        && st_ff.ctl[0].is_master && st_ff.ctl[0].byte_call
        |=> o_buf_en && o_rdata == `CALL_OPCODE)
        else $error("call opcode missing");
    // no in-service bit at or above the requested level
    a_int_raise: assert property (m_hp.found // [R14]
        && ((st_ff.ctl[0].in_service_levels & ((8'h02 << m_hp.lvl) - 8'h01)) == 8'h00) |=> o_int)
        else $error("interrupt not raised");

    c_poll_hit: cover property (i_io_rd && st_ff.ctl[0].poll_armed && m_hp.found);
    c_slave_ack: cover property (i_ack && st_ff.ctl[1].ack_st == ACK_BYTE1
        && st_ff.ctl[0].cas == st_ff.ctl[1].casc[2:0]);
    c_isr_read: cover property (i_io_rd && st_ff.ctl[0].sel_isr && !st_ff.ctl[0].poll_armed);
endmodule // interrupt_readback_poll_cascade

// File: host_model.sv
// Purpose: host processor model driving the board interrupt block
// Assumes: one clock; strobes start just after a rising edge
// Notes:   an answer missing after five edges reads back as unknown
`timescale 1ns/1ps

module host_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    output logic            o_io_rd,
    output logic            o_io_wr,
    output logic            o_ack,
    output logic [1:0]      o_port_addr,
    output logic [7:0]      o_wdata
);
    initial begin
        o_io_rd     = 1'b0;
        o_io_wr     = 1'b0;
        o_ack       = 1'b0;
        o_port_addr = 2'h0;
        o_wdata     = 8'h00;
    end

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_io_wr     <= 1'b1;
        o_port_addr <= a;
        o_wdata     <= d;
        @(posedge i_clk_sys);
        o_io_wr     <= 1'b0;
        o_wdata     <= ~d; // released bus must not keep the last value
    endtask

    task automatic take(output logic [7:0] d);
        logic got;
        got = 1'b0;
        d   = 8'hXX;
        for (int k = 0; k < 5 && !got; k++) begin
            #1;
            if (i_rd_valid === 1'b1) begin
                got = 1'b1;
                d   = i_rdata;
            end else begin
                @(posedge i_clk_sys);
            end
        end
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_io_rd     <= 1'b1;
        o_port_addr <= a;
        @(posedge i_clk_sys);
        o_io_rd     <= 1'b0;
        take(d);
    endtask

    task automatic ack(output logic [7:0] d);
        @(posedge i_clk_sys);
        o_ack <= 1'b1;
        @(posedge i_clk_sys);
        o_ack <= 1'b0;
        take(d);
    endtask

    // a fresh poll command before every poll read
    task automatic poll(input logic c, output logic [7:0] d);
        wr({c, 1'b0}, 8'h0C);
        rd({c, 1'b0}, d);
    endtask

    // full init even when only polling is used
    task automatic init_chip(input logic c, input logic [7:0] vec, cas, mode);
        wr({c, 1'b0}, 8'h10);
        wr({c, 1'b1}, vec);
        wr({c, 1'b1}, cas);
        wr({c, 1'b1}, mode);
    endtask
endmodule // host_model

// File: interrupt_readback_poll_cascade_tb.sv
// Purpose: self-checking bench for readback, poll and cascade
// Assumes: port 0/1 master even/odd, 2/3 slave even/odd
// Notes:   request lines idle high as if pulled up
`timescale 1ns/1ps

module interrupt_readback_poll_cascade_tb;
    localparam logic [7:0] PAGE = 8'h3C;
    logic       i_clk_sys = 1'b0;
    logic       i_rst_b   = 1'b0;
    logic [7:0] i_vi_n    = 8'hFF;
    logic [7:0] i_local_req = 8'h00;
    logic       io_rd, io_wr, ack, o_int, o_rd_valid, o_buf_en, o_addr_drive;
    logic [1:0] port_addr;
    logic [7:0] wdata, o_rdata, d;
    logic [2:0] o_addr_low;
    int         err_count  = 0;
    int         num_checks = 0;

    always #20 i_clk_sys = ~i_clk_sys;

    host_model host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .i_rd_valid(o_rd_valid),
        .o_io_rd(io_rd), .o_io_wr(io_wr), .o_ack(ack), .o_port_addr(port_addr),
        .o_wdata(wdata));

    interrupt_readback_poll_cascade #(.VEC_PAGE(PAGE)) DUT (.i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b), .i_io_rd(io_rd), .i_io_wr(io_wr), .i_port_addr(port_addr),
        .i_wdata(wdata), .i_ack(ack), .i_vi_n(i_vi_n), .i_local_req(i_local_req),
        .o_int(o_int), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_buf_en(o_buf_en),
        .o_addr_drive(o_addr_drive), .o_addr_low(o_addr_low));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host.rd(a, v);
        chk(v, exp);
    endtask

    // request lines pass a synchroniser, so let them settle
    task automatic vi(input logic [7:0] v);
        @(posedge i_clk_sys);
        i_vi_n <= v;
        repeat (8) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        host.init_chip(1'b0, 8'h40, 8'h02, 8'h04);
        host.init_chip(1'b1, 8'h80, 8'h01, 8'h00);
        rd_chk(2'h0, 8'h00);
        host.wr(2'h1, 8'hA5);
        rd_chk(2'h1, 8'hA5);
        rd_chk(2'h3, 8'h00);
        host.wr(2'h1, 8'h00);
        vi(8'hDF);
        rd_chk(2'h0, 8'h20);
        chk({7'h00, o_int}, 8'h01);
        host.wr(2'h0, 8'h0B);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h0, 8'h00);
        host.poll(1'b0, d);
        chk(d, 8'h85);
        rd_chk(2'h0, 8'h20);
        chk({7'h00, o_int}, 8'h00);
        vi(8'hFF);
        host.wr(2'h0, 8'h20);
        rd_chk(2'h0, 8'h00);
        host.poll(1'b1, d);
        chk(d, 8'h07);
        rd_chk(2'h2, 8'h00);
        vi(8'hDF);
        host.ack(d);
        chk({7'h00, o_addr_drive}, 8'h01);
        chk({5'h00, o_addr_low}, 8'h00);
        host.ack(d);
        chk(d, 8'h45);
        chk({7'h00, o_buf_en}, 8'h01);
        vi(8'hFF);
        chk({7'h00, o_addr_drive}, 8'h00);
        host.wr(2'h0, 8'h20);
        @(posedge i_clk_sys);
        i_local_req <= 8'h04;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk({7'h00, o_int}, 8'h01);
        host.ack(d);
        chk({5'h00, o_addr_low}, 8'h01);
        host.ack(d);
        chk(d, 8'h82);
        rd_chk(2'h0, 8'h02);
        host.wr(2'h2, 8'h0B);
        rd_chk(2'h2, 8'h04);
        @(posedge i_clk_sys);
        i_local_req <= 8'h00;
        host.wr(2'h2, 8'h62);
        rd_chk(2'h2, 8'h00);
        host.wr(2'h0, 8'h20);
        rd_chk(2'h0, 8'h00);
        vi(8'hFD);
        host.wr(2'h2, 8'h0A);
        rd_chk(2'h2, 8'h08);
        host.wr(2'h0, 8'h0A);
        rd_chk(2'h0, 8'h02);
        vi(8'hFF);
        host.init_chip(1'b0, 8'h40, 8'h02, 8'h07);
        vi(8'hDF);
        host.ack(d);
        chk(d, 8'hCD);
        host.ack(d);
        chk(d, 8'h54);
        host.ack(d);
        chk(d, PAGE);
        host.wr(2'h0, 8'h0B);
        rd_chk(2'h0, 8'h00);
        // second reset in mid-run must clear the mask again
        host.wr(2'h1, 8'h5A);
        @(posedge i_clk_sys);
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk({7'h00, o_addr_drive}, 8'h00);
        rd_chk(2'h1, 8'h00);
        report_and_stop();
    end
endmodule // interrupt_readback_poll_cascade_tb
